// ### design/can_mode_pkg.sv
package can_mode_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int         ADDR_W         = 4;
  localparam int         DATA_W         = 16;
  localparam logic [3:0] OFS_MODE_CTRL  = 4'h0;  // mode_control_reg
  localparam logic [3:0] OFS_FILTER_CNT = 4'h1;  // filter_bit_count_reg
  localparam logic [3:0] OFS_IRQ_CODE   = 4'h2;  // interrupt_code_reg

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_IDLE_STOP  = 13;
  localparam int POS_ABORT_ALL  = 12;
  localparam int POS_MODE_REQ   = 8;   // 10:8
  localparam int POS_MODE_CUR   = 5;   // 7:5
  localparam int POS_CAPTURE    = 3;
  localparam int POS_VIEW       = 0;
  localparam int POS_FILTER_HIT = 8;   // 11:8

  // ----------------------------------------------------------------
  // operating mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL      = 3'h0;
  localparam logic [2:0] MODE_DISABLE     = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK    = 3'h2;
  localparam logic [2:0] MODE_LISTEN_ONLY = 3'h3;
  localparam logic [2:0] MODE_CONFIG      = 3'h4;
  localparam logic [2:0] MODE_RSVD_A      = 3'h5;
  localparam logic [2:0] MODE_RSVD_B      = 3'h6;
  localparam logic [2:0] MODE_LISTEN_ALL  = 3'h7;
  localparam logic [2:0] MODE_RESET       = MODE_CONFIG;

  // ----------------------------------------------------------------
  // counts, limits and codes
  // ----------------------------------------------------------------
  localparam int         IDLE_BITS      = 11;     // recessive bits of bus idle
  localparam logic [1:0] MAX_OVERLOAD   = 2'h2;   // overload frames in a row
  localparam logic [4:0] CMP_COUNT_MAX  = 5'h11;  // highest valid compare count
  localparam logic [6:0] IRQ_NONE       = 7'h40;
  localparam logic [6:0] IRQ_ERROR      = 7'h41;
  localparam logic [6:0] IRQ_WAKE       = 7'h42;
  localparam logic [6:0] IRQ_OVERFLOW   = 7'h43;
  localparam logic [6:0] IRQ_ALMOST     = 7'h44;
  localparam int         CLK_NS         = 100;    // 10 MHz module clock
  localparam int         WAKE_LPF_NS    = 500;    // least dominant time to wake
  localparam int         WAKE_LPF_CYC   = (WAKE_LPF_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_enable;         // engine may transmit
    logic rx_enable;         // engine may receive
    logic send_err_ack;      // engine may send error flags and acks
    logic err_count_clear;   // hold error counters at zero
    logic err_count_freeze;  // hold error counters at their value
    logic ignore_errors;     // accept every message
    logic loopback;          // internal tx routed to internal rx
    logic tx_pin_own;        // block owns the transmit pin
    logic rx_pin_own;        // block owns the receive pin
  } mode_ctl_t;

  typedef struct packed {
    logic [15:0] buf_pend;   // buffers 0..15 pending
    logic        err;
    logic        wake;
    logic        ovf;
    logic        almost;
  } irq_src_t;

endpackage : can_mode_pkg

// ### design/bus_idle_detect.sv
`timescale 1ns/1ps
`default_nettype none

// counts recessive bit samples; any dominant sample restarts the count
module bus_idle_detect #(
  parameter int IDLE_BITS = can_mode_pkg::IDLE_BITS
) (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic bit_tick_i,   // sample point strobe
  input  wire logic rx_i,         // bus level, 1 = recessive
  input  wire logic restart_i,    // start a fresh idle period
  output logic      idle_o        // at least IDLE_BITS recessive bits seen
);

  logic [4:0] cnt_r;              // saturating recessive bit count

  // ----------------------------------------------------------------
  // recessive run counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 5'h00;
    end else if (restart_i) begin
      cnt_r <= 5'h00;
    end else if (bit_tick_i) begin
      if (!rx_i) begin
        cnt_r <= 5'h00;
      end else if (cnt_r < 5'(IDLE_BITS)) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  assign idle_o = (cnt_r >= 5'(IDLE_BITS));

endmodule : bus_idle_detect

`default_nettype wire

// ### design/can_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module can_mode_control #(
  parameter int LPF_CYC = can_mode_pkg::WAKE_LPF_CYC
) (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  // register port
  input  wire logic [3:0]             addr_i,
  input  wire logic [15:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [15:0]            rdata_o,
  // bus pins
  input  wire logic                   bus_rx_pin_i,
  output logic                        bus_tx_pin_o,
  output logic                        bus_tx_oe_n_o,
  output logic                        bus_rx_owned_o,
  // protocol engine side
  input  wire logic                   bit_tick_i,
  input  wire logic                   eng_tx_i,
  output logic                        eng_rx_o,
  input  wire logic                   tx_busy_i,
  input  wire logic                   in_ifs_i,
  input  wire logic                   rx_not_ready_i,
  input  wire logic                   sof_i,
  output logic                        overload_req_o,
  output can_mode_pkg::mode_ctl_t     mode_ctl_o,
  output logic                        cfg_write_ok_o,
  // buffers, filters and interrupts
  input  wire logic                   tx_req_i,
  output logic                        tx_start_ok_o,
  output logic                        tx_abort_o,
  output logic                        abort_all_o,
  input  wire logic                   all_aborted_i,
  input  wire logic                   msg_rx_i,
  input  wire logic [4:0]             filter_hit_i,
  output logic                        capture_o,
  output logic                        map_view_o,
  input  wire logic [4:0]             compare_count_i,
  output logic                        compare_valid_o,
  input  wire can_mode_pkg::irq_src_t irq_src_i,
  output logic                        wake_event_o,
  // power and configuration
  input  wire logic                   wake_lowpass_enable_i,
  input  wire logic                   sleep_i,
  input  wire logic                   cpu_idle_i,
  output logic                        halt_o
);

  // ----------------------------------------------------------------
  // state and declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,                 // mode stable
    ST_WAIT = 2'b10                  // change requested, waiting for idle
  } chg_state_t;

  chg_state_t  state_r;              // mode change sequencer
  logic [2:0]  mode_req_r;           // mode_request
  logic [2:0]  mode_cur_r;           // mode_current
  logic        idle_stop_r;          // idle_stop
  logic        abort_all_r;          // abort_all_tx
  logic        capture_en_r;         // rx_capture_enable
  logic        view_r;               // map_view_select
  logic [3:0]  filter_idx_r;         // matched_filter_index
  logic [6:0]  irq_code_r;           // irq_source_code
  logic [6:0]  irq_code_nxt;
  logic [1:0]  ovl_cnt_r;            // overload frames since last frame
  logic        entry_wait_r;         // new mode still waiting for idle
  logic        abort_done_r;         // entry-wait abort already signalled
  logic        rx_prev_r;            // previous bus level for wake edge
  logic        rx_filt_r;            // low-pass filtered receive level
  logic [3:0]  lpf_cnt_r;            // dominant run length
  logic [15:0] rdata_r;
  logic        bus_idle;
  logic        grant;
  logic        rx_eff;
  logic        wr_ctrl;
  logic        req_valid;
  can_mode_pkg::mode_ctl_t ctl;

  assign wr_ctrl   = wr_i && (addr_i == can_mode_pkg::OFS_MODE_CTRL);
  // reserved codes are never granted
  assign req_valid = (mode_req_r != can_mode_pkg::MODE_RSVD_A) &&
                     (mode_req_r != can_mode_pkg::MODE_RSVD_B);

  // ----------------------------------------------------------------
  // receive path and wake filter
  // ----------------------------------------------------------------
  // filter counts at all times; its output is used only while asleep with the filter enabled
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lpf_cnt_r <= 4'h0;
      rx_filt_r <= 1'b1;
    end else if (bus_rx_pin_i) begin
      lpf_cnt_r <= 4'h0;
      rx_filt_r <= 1'b1;
    end else if (lpf_cnt_r < 4'(LPF_CYC)) begin
      lpf_cnt_r <= lpf_cnt_r + 4'h1;
    end else begin
      rx_filt_r <= 1'b0;
    end
  end

  // short dominant glitches are hidden while asleep with the wake filter enabled
  assign rx_eff = (wake_lowpass_enable_i && sleep_i) ? rx_filt_r : bus_rx_pin_i;

  // ----------------------------------------------------------------
  // bus idle detection
  // ----------------------------------------------------------------
  bus_idle_detect #(
    .IDLE_BITS (can_mode_pkg::IDLE_BITS)
  ) u_idle (
    .mclk_i     (mclk_i),
    .reset_n_i  (reset_n_i),
    .bit_tick_i (bit_tick_i),
    .rx_i       (rx_eff),
    .restart_i  (grant),
    .idle_o     (bus_idle)
  );

  // grant needs idle; config entry also waits for the transmitter
  assign grant = (state_r == ST_WAIT) && req_valid && bus_idle &&
                 (mode_req_r != mode_cur_r) &&
                 !((mode_req_r == can_mode_pkg::MODE_CONFIG) && tx_busy_i);

  // ----------------------------------------------------------------
  // mode change sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r    <= ST_HOLD;
      mode_cur_r <= can_mode_pkg::MODE_RESET;
    end else begin
      case (state_r)
        ST_HOLD: begin
          if (req_valid && (mode_req_r != mode_cur_r)) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (grant) begin
            mode_cur_r <= mode_req_r;
            state_r    <= ST_HOLD;
          end else if (!req_valid || (mode_req_r == mode_cur_r)) begin
            state_r <= ST_HOLD;
          end
        end
        default: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-mode engine controls
  // ----------------------------------------------------------------
  always_comb begin
    ctl = '0;
    case (mode_cur_r)
      can_mode_pkg::MODE_NORMAL: begin
        ctl.tx_enable    = 1'b1;
        ctl.rx_enable    = 1'b1;
        ctl.send_err_ack = 1'b1;
        ctl.tx_pin_own   = 1'b1;
        ctl.rx_pin_own   = 1'b1;
      end
      can_mode_pkg::MODE_DISABLE: begin
        ctl.err_count_freeze = 1'b1;
      end
      can_mode_pkg::MODE_LOOPBACK: begin
        ctl.tx_enable    = 1'b1;
        ctl.rx_enable    = 1'b1;
        ctl.send_err_ack = 1'b1;
        ctl.loopback     = 1'b1;
      end
      can_mode_pkg::MODE_LISTEN_ONLY: begin
        ctl.rx_enable        = 1'b1;
        ctl.err_count_freeze = 1'b1;
        ctl.rx_pin_own       = 1'b1;
      end
      can_mode_pkg::MODE_LISTEN_ALL: begin
        ctl.rx_enable     = 1'b1;
        ctl.ignore_errors = 1'b1;
        ctl.rx_pin_own    = 1'b1;
      end
      can_mode_pkg::MODE_CONFIG: begin
        ctl.err_count_clear = 1'b1;
      end
      default: begin
        ctl = '0;
      end
    endcase
  end

  assign mode_ctl_o     = ctl;
  assign cfg_write_ok_o = (mode_cur_r == can_mode_pkg::MODE_CONFIG);
  assign halt_o         = idle_stop_r && cpu_idle_i;

  // ----------------------------------------------------------------
  // pins and loopback
  // ----------------------------------------------------------------
  assign bus_tx_pin_o   = ctl.tx_pin_own ? eng_tx_i : 1'b1;
  assign bus_tx_oe_n_o  = !ctl.tx_pin_own;
  assign bus_rx_owned_o = ctl.rx_pin_own;
  assign eng_rx_o       = ctl.loopback ? eng_tx_i : rx_eff;

  // ----------------------------------------------------------------
  // entry wait and transmit abort
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      entry_wait_r <= 1'b1;
      abort_done_r <= 1'b0;
    end else if (grant) begin
      entry_wait_r <= 1'b1;
      abort_done_r <= 1'b0;
    end else begin
      if (bus_idle) begin
        entry_wait_r <= 1'b0;
      end
      if (tx_abort_o) begin
        abort_done_r <= 1'b1;
      end
    end
  end

  assign tx_start_ok_o = ctl.tx_enable && !entry_wait_r && !halt_o;
  assign tx_abort_o    = entry_wait_r && ctl.tx_enable && tx_req_i && !abort_done_r &&
                         (mode_req_r == can_mode_pkg::MODE_DISABLE);

  // ----------------------------------------------------------------
  // overload frame requests
  // ----------------------------------------------------------------
  assign overload_req_o = in_ifs_i && bit_tick_i && (!rx_eff || rx_not_ready_i) &&
                          ctl.send_err_ack && !halt_o &&
                          (ovl_cnt_r < can_mode_pkg::MAX_OVERLOAD);

  // count restarts when a new frame begins
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovl_cnt_r <= 2'h0;
    end else if (sof_i) begin
      ovl_cnt_r <= 2'h0;
    end else if (overload_req_o) begin
      ovl_cnt_r <= ovl_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // wake detection in disable mode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_eff;
    end
  end

  assign wake_event_o = (mode_cur_r == can_mode_pkg::MODE_DISABLE) && rx_prev_r && !rx_eff;

  // ----------------------------------------------------------------
  // control register bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_req_r   <= can_mode_pkg::MODE_RESET;
      idle_stop_r  <= 1'b0;
      capture_en_r <= 1'b0;
      view_r       <= 1'b0;
    end else if (wr_ctrl) begin
      mode_req_r  <= wdata_i[can_mode_pkg::POS_MODE_REQ +: 3];
      idle_stop_r <= wdata_i[can_mode_pkg::POS_IDLE_STOP];
      view_r      <= wdata_i[can_mode_pkg::POS_VIEW];
      if (cfg_write_ok_o) begin
        capture_en_r <= wdata_i[can_mode_pkg::POS_CAPTURE];
      end
    end
  end

  // a set written in the same cycle as completion wins
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abort_all_r <= 1'b0;
    end else if (wr_ctrl && wdata_i[can_mode_pkg::POS_ABORT_ALL]) begin
      abort_all_r <= 1'b1;
    end else if (all_aborted_i) begin
      abort_all_r <= 1'b0;
    end
  end

  assign abort_all_o     = abort_all_r;
  assign capture_o       = capture_en_r && msg_rx_i;
  assign map_view_o      = view_r;
  assign compare_valid_o = (compare_count_i <= can_mode_pkg::CMP_COUNT_MAX);

  // ----------------------------------------------------------------
  // filter hit and interrupt code reports
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filter_idx_r <= 4'h0;
    end else if (msg_rx_i && !filter_hit_i[4]) begin
      filter_idx_r <= filter_hit_i[3:0];
    end
  end

  // lowest pending buffer first, then the module-level sources
  always_comb begin
    irq_code_nxt = can_mode_pkg::IRQ_NONE;
    if (irq_src_i.almost) irq_code_nxt = can_mode_pkg::IRQ_ALMOST;
    if (irq_src_i.ovf)    irq_code_nxt = can_mode_pkg::IRQ_OVERFLOW;
    if (irq_src_i.wake)   irq_code_nxt = can_mode_pkg::IRQ_WAKE;
    if (irq_src_i.err)    irq_code_nxt = can_mode_pkg::IRQ_ERROR;
    for (int i = 15; i >= 0; i--) begin
      if (irq_src_i.buf_pend[i]) irq_code_nxt = 7'(i);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_code_r <= can_mode_pkg::IRQ_NONE;
    end else begin
      irq_code_r <= irq_code_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register read port, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= 16'h0000;
    end else if (!rd_i) begin
      rdata_r <= 16'h0000;
    end else begin
      case (addr_i)
        can_mode_pkg::OFS_MODE_CTRL: begin
          rdata_r <= {2'b00, idle_stop_r, abort_all_r, 1'b0, mode_req_r,
                      mode_cur_r, 1'b0, capture_en_r, 2'b00, view_r};
        end
        can_mode_pkg::OFS_FILTER_CNT: begin
          rdata_r <= {11'h000, compare_count_i};
        end
        can_mode_pkg::OFS_IRQ_CODE: begin
          rdata_r <= {3'b000, 1'b0, filter_idx_r, 1'b0, irq_code_r};
        end
        default: begin
          rdata_r <= 16'h0000;
        end
      endcase
    end
  end

  assign rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_mode_needs_idle: assert property ($changed(mode_cur_r) |-> $past(bus_idle) && $past(req_valid))
    else $error("mode changed without bus idle");
  a_cfg_not_in_tx: assert property (
    $changed(mode_cur_r) && mode_cur_r == can_mode_pkg::MODE_CONFIG |-> !$past(tx_busy_i))
    else $error("config entered during transmission");
  a_overload_limit: assert property (overload_req_o |-> ovl_cnt_r < 2'h2 ##1 ovl_cnt_r != 2'h0)
    else $error("overload limit exceeded");
  a_overload_cause: assert property (overload_req_o |-> in_ifs_i && (!rx_eff || rx_not_ready_i))
    else $error("overload without cause");
  a_cfg_quiet: assert property (mode_cur_r == can_mode_pkg::MODE_CONFIG |->
    !mode_ctl_o.tx_enable && !mode_ctl_o.rx_enable && mode_ctl_o.err_count_clear)
    else $error("config mode not quiet");
  a_cfg_lock: assert property (wr_ctrl && !cfg_write_ok_o |=> $stable(capture_en_r))
    else $error("locked bit changed");
  a_loop_route: assert property (mode_cur_r == can_mode_pkg::MODE_LOOPBACK |->
    eng_rx_o == eng_tx_i && bus_tx_oe_n_o && !bus_rx_owned_o)
    else $error("loopback routing wrong");
  a_listen_passive: assert property (mode_cur_r == can_mode_pkg::MODE_LISTEN_ONLY |->
    !overload_req_o && bus_tx_oe_n_o && !tx_start_ok_o)
    else $error("listen-only not passive");
  a_abort_clears: assert property (abort_all_r && all_aborted_i && !wr_ctrl |=> !abort_all_r)
    else $error("abort bit not cleared");
  a_disable_code: assert property ($rose(mode_cur_r == can_mode_pkg::MODE_DISABLE) |->
    $past(mode_req_r) == can_mode_pkg::MODE_DISABLE)
    else $error("disable entered unrequested");

  c_enter_normal: cover property ($rose(mode_cur_r == can_mode_pkg::MODE_NORMAL));
  c_two_overloads: cover property (overload_req_o ##[1:300] overload_req_o);
  c_tx_abort: cover property (tx_abort_o);
  c_abort_all: cover property ($fell(abort_all_r));

endmodule : can_mode_control

`default_nettype wire

// ### sim/bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// far-side node: bit sample ticks and bus level
// ------------------------------------------------------------
module bus_node (
  input  wire logic       mclk_i,
  input  wire logic [3:0] dom_bits_i,  // dominant bits to send
  input  wire logic       go_i,        // start a dominant burst
  output logic            tick_o,      // sample point, every fourth clock
  output logic            rx_o         // 1 = recessive
);
  logic [1:0] div_r = 2'h0;  // clocks within a bit
  logic [3:0] dom_r = 4'h0;  // dominant bits left
  // bit timer and burst; line idles recessive through its pull-up
  always @(posedge mclk_i) begin
    div_r <= div_r + 2'h1;
    if (go_i) begin
      dom_r <= dom_bits_i;
    end else if (tick_o && dom_r != 4'h0) begin
      dom_r <= dom_r - 4'h1;
    end
  end
  assign tick_o = (div_r == 2'h3);
  assign rx_o   = (dom_r == 4'h0);
endmodule : bus_node
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk_i = 1'h0, reset_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, go = 1'h0, tick, rx;
  logic busy = 1'h0, aborted = 1'h0, msg = 1'h0, cidle = 1'h0, lo = 1'h0, oe_n, cfg_ok, cap, cmp_ok, halt;
  logic ab, view;  // abort_all_tx and map_view_select as the block drives them
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [4:0]  cmp = 5'h11, fh = 5'h05;
  logic [19:0] irq = 20'h0_0000;
  int failures = 0, n_tests = 0;
  always #50 mclk_i = ~mclk_i;  // 10 MHz
  bus_node i_bus_node (.mclk_i(mclk_i), .dom_bits_i(4'h1), .go_i(go), .tick_o(tick), .rx_o(rx));
  can_mode_control i_can_mode_control (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bus_rx_pin_i(rx), .bus_tx_pin_o(),
    .bus_tx_oe_n_o(oe_n), .bus_rx_owned_o(), .bit_tick_i(tick), .eng_tx_i(lo), .eng_rx_o(),
    .tx_busy_i(busy), .in_ifs_i(lo), .rx_not_ready_i(lo), .sof_i(lo), .overload_req_o(), .mode_ctl_o(),
    .cfg_write_ok_o(cfg_ok), .tx_req_i(lo), .tx_start_ok_o(), .tx_abort_o(), .abort_all_o(ab),
    .all_aborted_i(aborted), .msg_rx_i(msg), .filter_hit_i(fh), .capture_o(cap), .map_view_o(view),
    .compare_count_i(cmp), .compare_valid_o(cmp_ok), .irq_src_i(irq), .wake_event_o(),
    .wake_lowpass_enable_i(lo), .sleep_i(lo), .cpu_idle_i(cidle), .halt_o(halt));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'h1;
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'h1;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1 chk(rdata_o, e);
    // return on an edge so that callers drive the next inputs there
    @(posedge mclk_i);
  endtask : rd
  // wait a number of bus bits
  task bits(input int n);
    repeat (n * 4) @(posedge mclk_i);
  endtask : bits
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    rd(4'h0, 16'h0480);
    rd(4'h2, 16'h0040);
    wr(4'h0, 16'h0008);
    bits(13);
    rd(4'h0, 16'h0008);
    chk(oe_n, 1'h0);
    chk(cfg_ok, 1'h0);
    // dominant bit lands before the idle count completes
    wr(4'h0, 16'h0100);
    bits(2);
    go <= 1'h1;
    @(posedge mclk_i) go <= 1'h0;
    bits(8);
    rd(4'h0, 16'h0108);
    bits(6);
    rd(4'h0, 16'h0128);
    wr(4'h0, 16'h0500);
    bits(14);
    rd(4'h0, 16'h0528);
    $display("mode change tests done");
    busy <= 1'h1;
    wr(4'h0, 16'h0408);
    bits(14);
    rd(4'h0, 16'h0428);
    busy <= 1'h0;
    bits(14);
    chk(cfg_ok, 1'h1);
    wr(4'h0, 16'h3409);
    rd(4'h0, 16'h3489);
    chk(ab, 1'h1);
    chk(view, 1'h1);
    cidle <= 1'h1;
    aborted <= 1'h1;
    @(posedge mclk_i) aborted <= 1'h0;
    #1 chk(halt, 1'h1);
    chk(ab, 1'h0);
    rd(4'h0, 16'h2489);
    $display("config tests done");
    // capture pulse is looked at while the reception strobe stands
    msg <= 1'h1;
    #1 chk(cap, 1'h1);
    @(posedge mclk_i) msg <= 1'h0;
    irq <= 20'h0_0088;
    rd(4'h2, 16'h0503);
    for (int i = 0; i < 4; i++) begin
      irq <= {16'h0000, 4'h8 >> i};
      rd(4'h2, 16'h0541 + 16'(i));
    end
    chk(cmp_ok, 1'h1);
    rd(4'h1, 16'h0011);
    // loopback, then listen-only: both leave the transmit pin released
    wr(4'h0, 16'h0200);
    bits(12);
    rd(4'h0, 16'h0240);
    chk(oe_n, 1'h1);
    wr(4'h0, 16'h0300);
    bits(14);
    rd(4'h0, 16'h0360);
    chk(oe_n, 1'h1);
    $display("pin release tests done");
    cmp <= 5'h12;
    #200 chk(cmp_ok, 1'h0);
    $display("report tests done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
